/* usbemc_pkg.sv */
// Constants and types for the USB endpoint mode and count control block
package usbemc_pkg;
	localparam logic [6:0] OFF_MODE = 7'h00;
	localparam logic [6:0] OFF_CNT = 7'h20;
	localparam logic [6:0] OFF_IRQ = 7'h40;
	localparam int BIT_SETUP = 7;
	localparam int BIT_STALL = 7;
	localparam int BIT_IN = 6;
	localparam int BIT_OUT = 5;
	localparam int BIT_ACK = 4;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam int CRC_BYTES = 2;
	localparam logic [5:0] ZERO_LEN_CNT = 6'h02;
	localparam int DEF_NUM_EP = 5;
	localparam int DEF_PKT_BYTES = 8;
	localparam logic [3:0] MODE_DIS = 4'h0;
	localparam logic [3:0] MODE_NAK_IO = 4'h1;
	localparam logic [3:0] MODE_STAT_OUT = 4'h2;
	localparam logic [3:0] MODE_STALL_IO = 4'h3;
	localparam logic [3:0] MODE_IGN_IO = 4'h4;
	localparam logic [3:0] MODE_ISO_OUT = 4'h5;
	localparam logic [3:0] MODE_STAT_IN = 4'h6;
	localparam logic [3:0] MODE_ISO_IN = 4'h7;
	localparam logic [3:0] MODE_NAK_OUT = 4'h8;
	localparam logic [3:0] MODE_ACK_OUT = 4'h9;
	localparam logic [3:0] MODE_NAKO_STI = 4'hA;
	localparam logic [3:0] MODE_ACKO_STI = 4'hB;
	localparam logic [3:0] MODE_NAK_IN = 4'hC;
	localparam logic [3:0] MODE_ACK_IN = 4'hD;
	localparam logic [3:0] MODE_NAKI_STO = 4'hE;
	localparam logic [3:0] MODE_ACKI_STO = 4'hF;
	typedef enum logic [1:0] {
		TOK_SETUP = 2'b00,
		TOK_IN = 2'b01,
		TOK_OUT = 2'b10
	} usbemc_tok_t;
	typedef enum logic [2:0] {
		RESP_NONE = 3'b000,
		RESP_ACK = 3'b001,
		RESP_NAK = 3'b010,
		RESP_STALL = 3'b011,
		RESP_TX0 = 3'b100,
		RESP_TXCNT = 3'b101
	} usbemc_resp_t;
	typedef enum logic [2:0] {
		ACT_IGN = 3'b000,
		ACT_NAK = 3'b001,
		ACT_STALL = 3'b010,
		ACT_ACK = 3'b011,
		ACT_CHK = 3'b100,
		ACT_ALW = 3'b101,
		ACT_TX0 = 3'b110,
		ACT_TXC = 3'b111
	} usbemc_act_t;
	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_BUSY = 1'b1
	} usbemc_ph_t;
endpackage : usbemc_pkg

/* usbemc_top.sv */
// Endpoint mode and count control of the USB serial engine
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module usbemc_top #(
	parameter int NUM_EP = usbemc_pkg::DEF_NUM_EP,
	parameter int PKT_BYTES = usbemc_pkg::DEF_PKT_BYTES
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// Avalon-MM register slave
	input wire logic [6:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Packet layer events
	input wire logic tok_valid_in,
	input wire logic [1:0] tok_type_in,
	input wire logic [2:0] tok_ep_in,
	input wire logic data_start_in,
	input wire logic txn_end_in,
	input wire logic [5:0] rx_count_in,
	input wire logic rx_toggle_in,
	input wire logic rx_crc_ok_in,
	input wire logic host_ack_in,
	// Handshake request and interrupt flags
	output logic resp_valid_out,
	output logic [2:0] resp_out,
	output logic [NUM_EP-1:0] ep_irq_out
);
	localparam int MAX_RX = PKT_BYTES + usbemc_pkg::CRC_BYTES;

	generate
		if (NUM_EP < 2 || NUM_EP > 8 || PKT_BYTES < 1 || PKT_BYTES > 32)
		begin : g_bad_param
			$error("usbemc_top: NUM_EP or PKT_BYTES out of range");
		end
	endgenerate

	typedef struct packed {
		logic [NUM_EP-1:0][7:0] mode;
		logic [NUM_EP-1:0][7:0] cnt;
		logic [NUM_EP-1:0] irq;
		logic mode_lock;
		logic cnt_lock;
		logic setup_lock;
		logic setup_hold;
		usbemc_pkg::usbemc_ph_t ph;
		logic [2:0] ep;
		usbemc_pkg::usbemc_tok_t tok;
		usbemc_pkg::usbemc_act_t act;
		usbemc_pkg::usbemc_resp_t resp;
		logic resp_v;
		logic waitreq;
		logic [31:0] rdata;
		logic rd_fresh;
	} usbemc_state_t;

	function automatic usbemc_state_t f_rst();
		f_rst = '0;
		for (int i = 0; i < NUM_EP; i++)
		begin
			f_rst.mode[i] = usbemc_pkg::MODE_RST;
			f_rst.cnt[i] = usbemc_pkg::CNT_RST;
		end
		f_rst.waitreq = 1'b1;
	endfunction : f_rst

	localparam usbemc_state_t ST_RST = f_rst();

	function automatic logic f_setup_ok(input logic [3:0] m);
		case (m)
			usbemc_pkg::MODE_NAK_IO, usbemc_pkg::MODE_STAT_OUT,
			usbemc_pkg::MODE_STALL_IO, usbemc_pkg::MODE_IGN_IO,
			usbemc_pkg::MODE_STAT_IN, usbemc_pkg::MODE_NAKO_STI,
			usbemc_pkg::MODE_ACKO_STI, usbemc_pkg::MODE_NAKI_STO,
			usbemc_pkg::MODE_ACKI_STO: f_setup_ok = 1'b1;
			default: f_setup_ok = 1'b0;
		endcase
	endfunction : f_setup_ok

	function automatic usbemc_pkg::usbemc_act_t f_in_act(
		input logic [3:0] m, input logic st);
		case (m)
			usbemc_pkg::MODE_NAK_IO, usbemc_pkg::MODE_NAK_IN,
			usbemc_pkg::MODE_NAKI_STO: f_in_act = usbemc_pkg::ACT_NAK;
			usbemc_pkg::MODE_STAT_OUT,
			usbemc_pkg::MODE_STALL_IO: f_in_act = usbemc_pkg::ACT_STALL;
			usbemc_pkg::MODE_STAT_IN, usbemc_pkg::MODE_NAKO_STI,
			usbemc_pkg::MODE_ACKO_STI: f_in_act = usbemc_pkg::ACT_TX0;
			usbemc_pkg::MODE_ISO_IN,
			usbemc_pkg::MODE_ACKI_STO: f_in_act = usbemc_pkg::ACT_TXC;
			usbemc_pkg::MODE_ACK_IN: f_in_act = st ? usbemc_pkg::ACT_STALL
				: usbemc_pkg::ACT_TXC;
			default: f_in_act = usbemc_pkg::ACT_IGN;
		endcase
	endfunction : f_in_act

	function automatic usbemc_pkg::usbemc_act_t f_out_act(
		input logic [3:0] m, input logic st);
		case (m)
			usbemc_pkg::MODE_NAK_IO, usbemc_pkg::MODE_NAK_OUT,
			usbemc_pkg::MODE_NAKO_STI: f_out_act = usbemc_pkg::ACT_NAK;
			usbemc_pkg::MODE_STALL_IO,
			usbemc_pkg::MODE_STAT_IN: f_out_act = usbemc_pkg::ACT_STALL;
			usbemc_pkg::MODE_ACK_OUT: f_out_act = st ? usbemc_pkg::ACT_STALL
				: usbemc_pkg::ACT_ACK;
			usbemc_pkg::MODE_ACKO_STI: f_out_act = usbemc_pkg::ACT_ACK;
			usbemc_pkg::MODE_STAT_OUT, usbemc_pkg::MODE_NAKI_STO,
			usbemc_pkg::MODE_ACKI_STO: f_out_act = usbemc_pkg::ACT_CHK;
			usbemc_pkg::MODE_ISO_OUT: f_out_act = usbemc_pkg::ACT_ALW;
			default: f_out_act = usbemc_pkg::ACT_IGN;
		endcase
	endfunction : f_out_act

	// Mode taken after an ACK; 1010 and 1110 deliberately stay put
	function automatic logic [3:0] f_after_ack(input logic [3:0] m);
		case (m)
			usbemc_pkg::MODE_ACK_OUT: f_after_ack = usbemc_pkg::MODE_NAK_OUT;
			usbemc_pkg::MODE_ACKO_STI: f_after_ack = usbemc_pkg::MODE_NAKO_STI;
			usbemc_pkg::MODE_ACK_IN: f_after_ack = usbemc_pkg::MODE_NAK_IN;
			usbemc_pkg::MODE_ACKI_STO: f_after_ack = usbemc_pkg::MODE_NAKI_STO;
			default: f_after_ack = m;
		endcase
	endfunction : f_after_ack

	usbemc_state_t state_ff;
	usbemc_state_t nxt_state;
	logic [3:0] m;
	logic st;
	logic rx_ok;
	logic upd;
	logic ack;
	logic [1:0] bsel;
	logic [2:0] bidx;
	logic [31:0] rd_word;
	usbemc_pkg::usbemc_act_t act;
	usbemc_pkg::usbemc_resp_t hs;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.resp_v = 1'b0;
		m = '0;
		st = 1'b0;
		act = usbemc_pkg::ACT_IGN;
		hs = usbemc_pkg::RESP_NONE;
		upd = 1'b0;
		ack = 1'b0;
		rx_ok = rx_crc_ok_in && rx_count_in <= MAX_RX;
		bsel = avs_address_in[6:5];
		bidx = avs_address_in[4:2];
		rd_word = '0;
		if (bsel == usbemc_pkg::OFF_MODE[6:5] && bidx < NUM_EP)
			rd_word[7:0] = state_ff.mode[bidx];
		else if (bsel == usbemc_pkg::OFF_CNT[6:5] && bidx < NUM_EP)
			rd_word[7:0] = state_ff.cnt[bidx];
		else if (avs_address_in[6:2] == usbemc_pkg::OFF_IRQ[6:2])
			rd_word[NUM_EP-1:0] = state_ff.irq;

		// Bus access: data captured on the first edge, effects on the second
		if ((avs_read_in || avs_write_in) && state_ff.waitreq)
		begin
			nxt_state.waitreq = 1'b0;
			nxt_state.rdata = rd_word;
			nxt_state.rd_fresh = 1'b1;
		end
		else if (!state_ff.waitreq)
		begin
			nxt_state.waitreq = 1'b1;
			if (avs_read_in && bidx == 3'h0 && state_ff.rd_fresh)
			begin
				if (bsel == usbemc_pkg::OFF_MODE[6:5])
				begin
					nxt_state.mode_lock = 1'b0;
					nxt_state.setup_lock = state_ff.setup_hold;
				end
				if (bsel == usbemc_pkg::OFF_CNT[6:5])
					nxt_state.cnt_lock = 1'b0;
			end
			if (avs_write_in && avs_byteenable_in[0] && bidx < NUM_EP)
			begin
				if (bsel == usbemc_pkg::OFF_MODE[6:5] && bidx == 3'h0)
				begin
					if (!state_ff.mode_lock)
						nxt_state.mode[0][6:0] = avs_writedata_in[6:0];
					if (!(state_ff.setup_hold || state_ff.setup_lock))
						nxt_state.mode[0][usbemc_pkg::BIT_SETUP] =
							avs_writedata_in[usbemc_pkg::BIT_SETUP];
				end
				else if (bsel == usbemc_pkg::OFF_MODE[6:5])
					nxt_state.mode[bidx] = {avs_writedata_in[7], 2'b00,
						avs_writedata_in[4:0]};
				else if (bsel == usbemc_pkg::OFF_CNT[6:5] &&
					(bidx != 3'h0 || !state_ff.cnt_lock))
					nxt_state.cnt[bidx] = avs_writedata_in[7:0];
			end
			if (avs_write_in && avs_byteenable_in[0] &&
				avs_address_in[6:2] == usbemc_pkg::OFF_IRQ[6:2])
				nxt_state.irq = state_ff.irq & ~avs_writedata_in[NUM_EP-1:0];
		end

		// Token decode; non-IN handshakes wait for the data phase
		if (state_ff.ph == usbemc_pkg::PH_IDLE && tok_valid_in &&
			tok_ep_in < NUM_EP)
		begin
			m = state_ff.mode[tok_ep_in][3:0];
			st = state_ff.mode[tok_ep_in][usbemc_pkg::BIT_STALL] &&
				tok_ep_in != 3'h0;
			case (tok_type_in)
				usbemc_pkg::TOK_SETUP: act = f_setup_ok(m) ?
					usbemc_pkg::ACT_ACK : usbemc_pkg::ACT_IGN;
				usbemc_pkg::TOK_IN: act = f_in_act(m, st);
				usbemc_pkg::TOK_OUT: act = f_out_act(m, st);
				default: act = usbemc_pkg::ACT_IGN;
			endcase
			if (act != usbemc_pkg::ACT_IGN)
			begin
				nxt_state.ph = usbemc_pkg::PH_BUSY;
				nxt_state.ep = tok_ep_in;
				nxt_state.tok = usbemc_pkg::usbemc_tok_t'(tok_type_in);
				nxt_state.act = act;
			end
			if (tok_type_in == usbemc_pkg::TOK_IN &&
				act != usbemc_pkg::ACT_IGN)
			begin
				nxt_state.resp_v = 1'b1;
				unique case (act)
					usbemc_pkg::ACT_NAK: nxt_state.resp = usbemc_pkg::RESP_NAK;
					usbemc_pkg::ACT_STALL: nxt_state.resp = usbemc_pkg::RESP_STALL;
					usbemc_pkg::ACT_TX0: nxt_state.resp = usbemc_pkg::RESP_TX0;
					default: nxt_state.resp = usbemc_pkg::RESP_TXCNT;
				endcase
			end
		end

		// SETUP point: pin the SETUP bit for the whole data phase
		if (state_ff.ph == usbemc_pkg::PH_BUSY && data_start_in &&
			state_ff.tok == usbemc_pkg::TOK_SETUP && state_ff.ep == 3'h0)
		begin
			nxt_state.mode[0][usbemc_pkg::BIT_SETUP] = 1'b1;
			nxt_state.setup_hold = 1'b1;
			nxt_state.setup_lock = 1'b1;
		end

		// UPDATE point; placed last so engine sets win over CPU writes
		if (state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in)
		begin
			nxt_state.ph = usbemc_pkg::PH_IDLE;
			m = state_ff.mode[state_ff.ep][3:0];
			upd = 1'b1;
			unique case (state_ff.tok)
				usbemc_pkg::TOK_SETUP:
				begin
					nxt_state.cnt[state_ff.ep] = {rx_toggle_in, rx_ok,
						rx_count_in};
					nxt_state.setup_hold = 1'b0;
					hs = rx_ok ? usbemc_pkg::RESP_ACK : usbemc_pkg::RESP_NONE;
				end
				usbemc_pkg::TOK_OUT:
				begin
					upd = rx_ok;
					case (state_ff.act)
						usbemc_pkg::ACT_NAK: if (rx_ok)
							hs = usbemc_pkg::RESP_NAK;
						usbemc_pkg::ACT_STALL: if (rx_ok)
						begin
							hs = usbemc_pkg::RESP_STALL;
							if (m == usbemc_pkg::MODE_STAT_IN)
								nxt_state.mode[state_ff.ep][3:0] =
									usbemc_pkg::MODE_STALL_IO;
						end
						usbemc_pkg::ACT_CHK: if (rx_ok)
						begin
							hs = (rx_count_in == usbemc_pkg::ZERO_LEN_CNT &&
								rx_toggle_in) ? usbemc_pkg::RESP_ACK
								: usbemc_pkg::RESP_STALL;
							if (hs == usbemc_pkg::RESP_ACK)
								nxt_state.cnt[state_ff.ep] = {rx_toggle_in,
									rx_ok, rx_count_in};
						end
						default:
						begin
							upd = 1'b1;
							nxt_state.cnt[state_ff.ep] = {rx_toggle_in, rx_ok,
								rx_count_in};
							if (rx_ok && state_ff.act == usbemc_pkg::ACT_ACK)
								hs = usbemc_pkg::RESP_ACK;
						end
					endcase
				end
				usbemc_pkg::TOK_IN: ack = host_ack_in &&
					(state_ff.act == usbemc_pkg::ACT_TX0 ||
					state_ff.act == usbemc_pkg::ACT_TXC);
				default: upd = 1'b0;
			endcase
			if (hs == usbemc_pkg::RESP_ACK)
				ack = 1'b1;
			if (upd)
			begin
				nxt_state.irq[state_ff.ep] = 1'b1;
				if (state_ff.ep == 3'h0)
				begin
					if (state_ff.tok == usbemc_pkg::TOK_IN)
						nxt_state.mode[0][usbemc_pkg::BIT_IN] = 1'b1;
					if (state_ff.tok == usbemc_pkg::TOK_OUT)
						nxt_state.mode[0][usbemc_pkg::BIT_OUT] = 1'b1;
					nxt_state.mode_lock = 1'b1;
					nxt_state.cnt_lock = 1'b1;
					nxt_state.rd_fresh = 1'b0;
				end
			end
			if (ack)
			begin
				nxt_state.mode[state_ff.ep][usbemc_pkg::BIT_ACK] = 1'b1;
				// A host ACK of a zero-length status IN leaves the mode alone
				if (state_ff.tok == usbemc_pkg::TOK_SETUP)
					nxt_state.mode[state_ff.ep][3:0] =
						usbemc_pkg::MODE_NAK_IO;
				else if (state_ff.act != usbemc_pkg::ACT_TX0)
					nxt_state.mode[state_ff.ep][3:0] =
						f_after_ack(m);
			end
			if (hs != usbemc_pkg::RESP_NONE)
			begin
				nxt_state.resp_v = 1'b1;
				nxt_state.resp = hs;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state_ff <= ST_RST;
		else
			state_ff <= nxt_state;
	end

	assign avs_readdata_out = state_ff.rdata;
	assign avs_waitrequest_out = state_ff.waitreq;
	assign resp_valid_out = state_ff.resp_v;
	assign resp_out = state_ff.resp;
	assign ep_irq_out = state_ff.irq;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	a_irq_at_update: assert property (
		(state_ff.irq & ~$past(state_ff.irq)) != '0 |->
		$past(state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in))
		else $error("interrupt flag set outside the update point");

	a_setup_to_nak: assert property (
		state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in && rx_ok &&
		state_ff.tok == usbemc_pkg::TOK_SETUP |=>
		state_ff.mode[$past(state_ff.ep)][3:0] == usbemc_pkg::MODE_NAK_IO &&
		resp_valid_out && resp_out == usbemc_pkg::RESP_ACK)
		else $error("valid SETUP did not ACK and move to 0001");

	a_disabled_quiet: assert property (
		state_ff.ph == usbemc_pkg::PH_IDLE && tok_valid_in &&
		tok_ep_in < NUM_EP &&
		state_ff.mode[tok_ep_in][3:0] == usbemc_pkg::MODE_DIS |=>
		state_ff.ph == usbemc_pkg::PH_IDLE && !resp_valid_out)
		else $error("disabled endpoint answered a token");

	a_lock_cause: assert property (
		$rose(state_ff.mode_lock) |-> $past(state_ff.ph ==
		usbemc_pkg::PH_BUSY && txn_end_in && state_ff.ep == 3'h0))
		else $error("EP0 lock set without an EP0 update");

	a_unlock_by_read: assert property (
		$fell(state_ff.mode_lock) |-> $past(avs_read_in &&
		!state_ff.waitreq && state_ff.rd_fresh &&
		avs_address_in == usbemc_pkg::OFF_MODE))
		else $error("EP0 mode unlocked without a fresh read");

	a_setup_held: assert property (
		state_ff.setup_hold |-> state_ff.mode[0][usbemc_pkg::BIT_SETUP])
		else $error("SETUP bit low during SETUP data phase");

	a_ep1_never_locks: assert property (
		!state_ff.waitreq && avs_write_in && avs_byteenable_in[0] &&
		avs_address_in == usbemc_pkg::OFF_MODE + 7'h04 &&
		!(state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in) |=>
		state_ff.mode[1][4:0] == $past(avs_writedata_in[4:0]))
		else $error("write to EP1 mode was not taken");

	a_ack_out_next: assert property (
		state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in && rx_ok &&
		state_ff.tok == usbemc_pkg::TOK_OUT &&
		state_ff.act == usbemc_pkg::ACT_ACK &&
		state_ff.mode[state_ff.ep][3:0] == usbemc_pkg::MODE_ACK_OUT |=>
		state_ff.mode[$past(state_ff.ep)][3:0] == usbemc_pkg::MODE_NAK_OUT)
		else $error("mode 1001 did not move to 1000 after ACK");

	a_status_check: assert property (
		state_ff.ph == usbemc_pkg::PH_BUSY && txn_end_in && rx_ok &&
		state_ff.tok == usbemc_pkg::TOK_OUT &&
		state_ff.act == usbemc_pkg::ACT_CHK |=> resp_valid_out &&
		resp_out == (($past(rx_count_in) == usbemc_pkg::ZERO_LEN_CNT &&
		$past(rx_toggle_in)) ? usbemc_pkg::RESP_ACK : usbemc_pkg::RESP_STALL))
		else $error("status check answered wrongly");

	a_in_stall: assert property (
		state_ff.ph == usbemc_pkg::PH_IDLE && tok_valid_in &&
		tok_type_in == usbemc_pkg::TOK_IN && tok_ep_in == 3'h1 &&
		state_ff.mode[1] == {1'b1, 3'b000, usbemc_pkg::MODE_ACK_IN} |=>
		resp_valid_out && resp_out == usbemc_pkg::RESP_STALL)
		else $error("stalled 1101 endpoint did not stall IN");
endmodule : usbemc_top

/* usbemc_host_model.sv */
// Behavioural USB host that issues tokens and data events to the block
`timescale 1ns/1ps
module usbemc_host_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Responses from the block
	input wire logic resp_valid_in,
	input wire logic [2:0] resp_in,
	// Packet layer events
	output logic tok_valid_out,
	output logic [1:0] tok_type_out,
	output logic [2:0] tok_ep_out,
	output logic data_start_out,
	output logic txn_end_out,
	output logic [5:0] rx_count_out,
	output logic rx_toggle_out,
	output logic rx_crc_ok_out,
	output logic host_ack_out
);
	logic [2:0] last_resp = 3'h0;
	int resp_n = 0;
	initial
	begin
		tok_valid_out = 1'b0;
		tok_type_out = 2'h3;
		tok_ep_out = 3'h7;
		data_start_out = 1'b0;
		txn_end_out = 1'b0;
		rx_count_out = 6'h3F;
		rx_toggle_out = 1'b0;
		rx_crc_ok_out = 1'b0;
		host_ack_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk_in);
			if (resp_valid_in === 1'b1)
			begin
				last_resp = resp_in;
				resp_n++;
			end
		end
	endtask : tick
	// Qualifiers are inverted outside their pulse so stale values never match
	task automatic txn(input logic [1:0] t, input logic [2:0] e,
		input logic [5:0] c, input logic tg, input logic ak, input int gap);
		last_resp = 3'h0;
		resp_n = 0;
		@(posedge clk_in);
		tok_valid_out <= 1'b1;
		tok_type_out <= t;
		tok_ep_out <= e;
		tick(1);
		tok_valid_out <= 1'b0;
		tok_type_out <= ~t;
		tok_ep_out <= ~e;
		tick(gap + 1);
		if (t == usbemc_pkg::TOK_SETUP)
		begin
			data_start_out <= 1'b1;
			tick(1);
			data_start_out <= 1'b0;
			tick(gap + 1);
		end
		txn_end_out <= 1'b1;
		rx_count_out <= c;
		rx_toggle_out <= tg;
		rx_crc_ok_out <= 1'b1;
		host_ack_out <= ak;
		tick(1);
		txn_end_out <= 1'b0;
		rx_count_out <= ~c;
		rx_toggle_out <= ~tg;
		rx_crc_ok_out <= 1'b0;
		host_ack_out <= ~ak;
		tick(3);
	endtask : txn
endmodule : usbemc_host_model

/* usbemc_top_tb_top.sv */
// Self-checking bench for the endpoint mode and count control block
`timescale 1ns/1ps
module usbemc_top_tb_top;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [6:0] avs_address_in = 7'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic tok_valid_in, data_start_in, txn_end_in, rx_toggle_in;
	logic rx_crc_ok_in, host_ack_in, resp_valid_out;
	logic [1:0] tok_type_in;
	logic [2:0] tok_ep_in, resp_out;
	logic [5:0] rx_count_in;
	logic [4:0] ep_irq_out;
	int miscompares = 0;
	int comparisons = 0;
	int seed = 94;
	usbemc_top i_usbemc_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .tok_valid_in(tok_valid_in),
		.tok_type_in(tok_type_in), .tok_ep_in(tok_ep_in),
		.data_start_in(data_start_in), .txn_end_in(txn_end_in),
		.rx_count_in(rx_count_in), .rx_toggle_in(rx_toggle_in),
		.rx_crc_ok_in(rx_crc_ok_in), .host_ack_in(host_ack_in),
		.resp_valid_out(resp_valid_out), .resp_out(resp_out),
		.ep_irq_out(ep_irq_out));
	usbemc_host_model i_usbemc_host_model (.clk_in(clk_sys_in),
		.resetn_in(resetn_in), .resp_valid_in(resp_valid_out),
		.resp_in(resp_out), .tok_valid_out(tok_valid_in),
		.tok_type_out(tok_type_in), .tok_ep_out(tok_ep_in),
		.data_start_out(data_start_in), .txn_end_out(txn_end_in),
		.rx_count_out(rx_count_in), .rx_toggle_out(rx_toggle_in),
		.rx_crc_ok_out(rx_crc_ok_in), .host_ack_out(host_ack_in));
	initial
	begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic end_of_test;
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [6:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		q = avs_readdata_out;
		if (n >= 50)
			miscompares++;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [6:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, q, exp);
	endtask : rd_chk
	function automatic logic [6:0] ma(input int e);
		return usbemc_pkg::OFF_MODE + 7'(4 * e);
	endfunction : ma
	function automatic logic [6:0] ca(input int e);
		return usbemc_pkg::OFF_CNT + 7'(4 * e);
	endfunction : ca
	function automatic logic [2:0] exp_resp(input logic [3:0] m,
		input logic ti, input logic st, input logic [5:0] len, input logic tg);
		logic ok;
		ok = (len == 6'h00) && tg;
		if (ti)
			case (m)
				4'h1, 4'hC, 4'hE: return usbemc_pkg::RESP_NAK;
				4'h2, 4'h3: return usbemc_pkg::RESP_STALL;
				4'h6, 4'hA, 4'hB: return usbemc_pkg::RESP_TX0;
				4'h7, 4'hF: return usbemc_pkg::RESP_TXCNT;
				4'hD: return st ? usbemc_pkg::RESP_STALL : usbemc_pkg::RESP_TXCNT;
				default: return usbemc_pkg::RESP_NONE;
			endcase
		case (m)
			4'h1, 4'h8, 4'hA: return usbemc_pkg::RESP_NAK;
			4'h3, 4'h6: return usbemc_pkg::RESP_STALL;
			4'h9: return st ? usbemc_pkg::RESP_STALL : usbemc_pkg::RESP_ACK;
			4'hB: return usbemc_pkg::RESP_ACK;
			4'h2, 4'hE, 4'hF: return ok ? usbemc_pkg::RESP_ACK : usbemc_pkg::RESP_STALL;
			default: return usbemc_pkg::RESP_NONE;
		endcase
	endfunction : exp_resp
	function automatic logic [3:0] exp_next(input logic [3:0] m,
		input logic ti, input logic [2:0] r);
		if (ti)
			return (r == usbemc_pkg::RESP_TXCNT && m[3:2] == 2'b11) ? {m[3:1], 1'b0} : m;
		if (r == usbemc_pkg::RESP_ACK && m[3] && m[0])
			return {m[3:1], 1'b0};
		return (m == 4'h6 && r == usbemc_pkg::RESP_STALL) ? 4'h3 : m;
	endfunction : exp_next
	initial
	begin
		repeat (30000) @(posedge clk_sys_in);
		miscompares++;
		end_of_test();
	end
	initial
	begin
		logic [31:0] rv, q;
		logic [3:0] m;
		logic [2:0] r;
		logic [5:0] len;
		logic ti, st, tg;
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		for (int e = 0; e < 5; e++)
		begin
			rd_chk("mode_rst", ma(e), 32'h0);
			rd_chk("cnt_rst", ca(e), 32'h0);
		end
		rd_chk("unmapped", 7'h60, 32'h0);
		avs_byteenable_in <= 4'h0;
		wr(ma(1), 32'h5);
		avs_byteenable_in <= 4'hF;
		rd_chk("lane_off", ma(1), 32'h0);
		wr(ma(0), 32'h01);
		fork
			i_usbemc_host_model.txn(usbemc_pkg::TOK_SETUP, 3'h0, 6'hA, 1'b0, 1'b0, 30);
			begin
				// Firmware pokes during the data phase, before the update
				repeat (40) @(posedge clk_sys_in);
				rd_chk("setup_hold", ma(0), 32'h81);
				wr(ma(0), 32'h01);
			end
		join
		chk("setup_resp", i_usbemc_host_model.last_resp, usbemc_pkg::RESP_ACK);
		chk("irq0", ep_irq_out[0], 1'b1);
		wr(ma(0), 32'h03);
		wr(ca(0), 32'h05);
		rd_chk("mode0_lock", ma(0), 32'h91);
		rd_chk("cnt0_lock", ca(0), 32'h4A);
		wr(ma(0), 32'h0F);
		wr(ca(0), 32'h05);
		rd_chk("mode0_open", ma(0), 32'h0F);
		rd_chk("cnt0_open", ca(0), 32'h05);
		wr(usbemc_pkg::OFF_IRQ, 32'h1);
		i_usbemc_host_model.txn(usbemc_pkg::TOK_OUT, 3'h0, 6'h2, 1'b1, 1'b0, 1);
		chk("status_out", i_usbemc_host_model.last_resp, usbemc_pkg::RESP_ACK);
		rd_chk("mode0_out", ma(0), 32'h3E);
		rd_chk("cnt0_out", ca(0), 32'hC2);
		i_usbemc_host_model.txn(usbemc_pkg::TOK_IN, 3'h0, 6'h2, 1'b0, 1'b0, 1);
		rd_chk("mode0_in", ma(0), 32'h7E);
		wr(usbemc_pkg::OFF_IRQ, 32'h1F);
		// Endpoint 1 is swept through all 16 modes with IN and OUT tokens only, never SETUP
		for (int k = 0; k < 96; k++)
		begin
			rv = $random(seed);
			m = k[3:0];
			ti = k[4];
			st = (k[6] | (rv[6] & k[5])) & (m == 4'h9 || m == 4'hD);
			tg = rv[5];
			len = rv[0] ? 6'h00 : {3'b000, rv[3:1]};
			wr(ma(1), {24'h0, st, 3'b000, m});
			wr(ca(1), {29'h0, rv[10:8]});
			i_usbemc_host_model.txn(ti ? usbemc_pkg::TOK_IN : usbemc_pkg::TOK_OUT,
				3'h1, len + 6'h2, tg, m != 4'h7, 1);
			r = exp_resp(m, ti, st, len, tg);
			chk("resp", i_usbemc_host_model.last_resp, r);
			chk("resp_n", i_usbemc_host_model.resp_n, r != 3'h0);
			bus(1'b0, ma(1), 32'h0, q);
			chk("mode1", {q[7], q[3:0]}, {st, exp_next(m, ti, r)});
			if (m != 4'h5 && m != 4'h7)
				chk("irq1", ep_irq_out[1], r != 3'h0);
			wr(usbemc_pkg::OFF_IRQ, 32'h2);
			if (!ti && r == usbemc_pkg::RESP_ACK)
			begin
				rd_chk("cnt1", ca(1), {24'h0, tg, 1'b1, len + 6'h2});
				wr(ca(1), 32'h15);
				rd_chk("cnt1_free", ca(1), 32'h15);
			end
		end
		end_of_test();
	end
endmodule : usbemc_top_tb_top
